// ### logic/bssc_core.sv
/*
 * Borrow-subtract and scan-compare execution datapath with its register file
 * on a classic Wishbone slave and a request/acknowledge port to data memory.
 * Assumes the memory port runs on i_sys_clk, holds ack for one cycle per
 * request, and places read data in the low bits.
 */
// How it works
// [RQ1] result is dest minus (source plus carry)
// [RQ2] immediates are sign-extended to destination width
// [RQ3] 1C/1D subtract immediate from accumulator
// [RQ4] 80/81/83 with reg 3 subtract immediate
// [RQ5] 18/19 reg from r/m; 1A/1B r/m from reg
// [RQ6] overflow, carry and sign from both interpretations
// [RQ7] zero, aux-carry, parity follow the result too
// [RQ8] AE/AF compare accumulator with memory, set flags
// [RQ9] scan operand at scan segment, 16/32-bit pointer
// [RQ10] segment override ignored, scan segment always used
// [RQ11] direction flag picks pointer increment or decrement
// [RQ12] pointer step is 1, 2 or 4
// [RQ13] iteration prefix repeats over repeat counter
// [RQ14] protected: nonwritable, limit, null selector give GP(0)
// [RQ15] stack limit exceeded gives SS(0)
// [RQ16] memory page fault reported with its code
// [RQ17] alignment fault: protected at level 3, v86 always
// [RQ18] real mode: GP and SS without error code
// [RQ19] scan sets all six flags, stores nothing
// [RQ20] fault suppresses writes, flags and pointer step
// [RQ21] counter decrements per compare, stops at zero
`timescale 1ns/1ps

module bssc_core
    import bssc_pkg::*;
(
    input  wire logic          i_sys_clk,
    input  wire logic          i_resetn,
    input  wire logic          i_wb_cyc,
    input  wire logic          i_wb_stb,
    input  wire logic          i_wb_we,
    input  wire logic [7:0]    i_wb_adr,
    input  wire logic [3:0]    i_wb_sel,
    input  wire logic [31:0]   i_wb_dat,
    output logic      [31:0]   o_wb_dat,
    output logic               o_wb_ack,
    output bssc_mem_req_t      o_mem,
    input  wire bssc_mem_rsp_t i_mem,
    output logic               o_busy,
    output logic               o_done
);

    // =========================================================================
    // state
    logic [31:0]   regs_q [REG_WORDS];
    bssc_state_t   state_q;
    bssc_state_t   state_d;
    logic [31:0]   memdat_q;
    logic          done_q;
    logic          illegal_q;
    bssc_fault_t   fkind_q;
    logic          errv_q;
    logic [15:0]   fcode_q;
    logic          fin;
    logic          commit;

    // =========================================================================
    // bus decode
    wire [5:0]  bus_idx  = i_wb_adr[7:2];
    wire        bus_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire        bus_map  = bus_idx < 6'(REG_WORDS);
    // writes are refused while an operation runs so software cannot race it
    wire        bus_wr   = bus_req & i_wb_we & bus_map & (state_q == ST_IDLE);
    wire        start    = bus_wr & (bus_idx == OFF_CTRL[7:2]) & i_wb_sel[3]
                         & i_wb_dat[CTRL_START];
    wire [31:0] sel_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                            {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire [31:0] wr_word  = (regs_q[bus_idx[3:0]] & ~sel_mask) | (i_wb_dat & sel_mask);

    // =========================================================================
    // control word decode
    wire [31:0] ctrl       = regs_q[OFF_CTRL[5:2]];
    wire [7:0]  opc        = ctrl[CTRL_OPC_LSB +: 8];
    wire [2:0]  reg_sel    = ctrl[CTRL_REG_LSB +: 3];
    wire        rm_mem     = ctrl[CTRL_RM_MEM];
    wire        size16     = ctrl[CTRL_SIZE16];
    wire        iter_pfx   = ctrl[CTRL_ITER_PFX];
    wire [1:0]  mode       = ctrl[CTRL_MODE_LSB +: 2];
    wire [1:0]  cpl        = ctrl[CTRL_CPL_LSB +: 2];
    wire        prot       = mode == MODE_PROT;
    wire        v86        = mode == MODE_V86;

    wire is_acc    = (opc == OPC_ACC_IMM_B) | (opc == OPC_ACC_IMM_W);          // [RQ3]
    wire is_grp    = ((opc == OPC_GRP_IMM_B) | (opc == OPC_GRP_IMM_W)
                   | (opc == OPC_GRP_IMM_S)) & (reg_sel == GRP_SBB_SEL);      // [RQ4]
    wire is_rmdst  = (opc == OPC_RM_REG_B) | (opc == OPC_RM_REG_W);            // [RQ5]
    wire is_regdst = (opc == OPC_REG_RM_B) | (opc == OPC_REG_RM_W);            // [RQ5]
    wire is_scan   = (opc == OPC_SCAN_B) | (opc == OPC_SCAN_W);                // [RQ8]
    wire legal     = is_acc | is_grp | is_rmdst | is_regdst | is_scan;
    wire imm_short = (opc == OPC_GRP_IMM_B) | (opc == OPC_GRP_IMM_S)
                   | (opc == OPC_ACC_IMM_B);
    wire is_imm    = is_acc | is_grp;
    wire uses_mem  = is_scan | (rm_mem & (is_grp | is_rmdst | is_regdst));
    wire mem_dest  = rm_mem & (is_grp | is_rmdst);

    // even opcodes of every listed pair are the byte forms
    wire [2:0]  nbytes = ~opc[0] ? 3'd1 : (size16 ? 3'd2 : 3'd4);
    wire [31:0] wmask  = ~opc[0] ? 32'h0000_00ff : (size16 ? 32'h0000_ffff : 32'hffff_ffff);
    wire [4:0]  msb    = ~opc[0] ? 5'd7 : (size16 ? 5'd15 : 5'd31);

    // =========================================================================
    // operand selection
    wire [31:0]  acc     = regs_q[OFF_ACC[5:2]];
    wire [31:0]  dst     = regs_q[OFF_DEST[5:2]];
    wire [31:0]  src     = regs_q[OFF_SRC[5:2]];
    wire [31:0]  ptr     = regs_q[OFF_SPTR[5:2]];
    wire [31:0]  rcnt    = regs_q[OFF_RCNT[5:2]];
    wire [31:0]  imm_ext = imm_short ? {{24{src[7]}}, src[7:0]} : src;       // [RQ2]
    wire bssc_flags_t flags = bssc_flags_t'(regs_q[OFF_FLAGS[5:2]][6:0]);

    wire [31:0] opd = (is_acc | is_scan) ? acc
                    : (mem_dest ? memdat_q : dst);                             // [RQ1]
    wire [31:0] ops = is_scan ? memdat_q
                    : is_imm ? imm_ext
                    : ((is_regdst & rm_mem) ? memdat_q : src);
    // a compare is a plain subtract: no borrow comes in
    wire        cin = is_scan ? 1'b0 : flags.carry_flag;                       // [RQ8]

    // =========================================================================
    // subtract and flags
    wire [31:0] a_m  = opd & wmask;
    wire [31:0] b_m  = ops & wmask;
    wire [32:0] full = {1'b0, a_m} - {1'b0, b_m} - {32'h0, cin};               // [RQ1]
    wire [31:0] res  = full[31:0] & wmask;
    wire        a_s  = a_m[msb];
    wire        b_s  = b_m[msb];
    wire        r_s  = res[msb];

    bssc_flags_t new_flags;
    assign new_flags.direction_flag = flags.direction_flag;
    assign new_flags.overflow_flag  = (a_s ^ b_s) & (r_s ^ a_s);               // [RQ6]
    assign new_flags.sign_flag      = r_s;                                     // [RQ6]
    // masked operands make bit 32 the borrow at every width
    assign new_flags.carry_flag     = full[32];                                // [RQ6]
    assign new_flags.zero_flag      = res == 32'h0;                            // [RQ7]
    assign new_flags.aux_carry_flag = a_m[4] ^ b_m[4] ^ res[4];                // [RQ7]
    assign new_flags.parity_flag    = ~^res[7:0];                              // [RQ7]

    // =========================================================================
    // addressing and fault checks
    wire [31:0] ptr_off = size16 ? {16'h0, ptr[15:0]} : ptr;                  // [RQ9]
    // scan always goes through its own segment; no override input exists
    wire [31:0] off     = is_scan ? ptr_off : regs_q[OFF_MADDR[5:2]];          // [RQ10]
    wire [31:0] base    = is_scan ? regs_q[OFF_SBASE[5:2]] : regs_q[OFF_MBASE[5:2]];
    wire [31:0] limit   = is_scan ? regs_q[OFF_SLIMIT[5:2]] : regs_q[OFF_MLIMIT[5:2]];
    wire        nullsel = is_scan ? ctrl[CTRL_SSEG_NULL] : ctrl[CTRL_MSEG_NULL];
    wire        stack   = ~is_scan & ctrl[CTRL_MSEG_STK];
    wire [31:0] lin     = base + off;
    wire [32:0] last    = {1'b0, off} + {30'h0, nbytes} - 33'h1;
    wire        over    = last > {1'b0, limit};
    wire        unal    = (off[1:0] & (nbytes[1:0] - 2'h1)) != 2'h0;
    wire        ac_live = ctrl[CTRL_AC_EN] & (v86 | (prot & (cpl == CPL_USER)));  // [RQ17]

    bssc_fault_t chk_fault;
    always_comb begin
        chk_fault = FLT_NONE;
        if (prot & mem_dest & ~ctrl[CTRL_MSEG_WR]) begin
            chk_fault = FLT_GP;                                                // [RQ14]
        end else if (prot & nullsel & ~stack) begin
            chk_fault = FLT_GP;                                                // [RQ14]
        end else if (over) begin
            chk_fault = stack ? FLT_SS : FLT_GP;                               // [RQ15] [RQ18]
        end else if (ac_live & unal) begin
            chk_fault = FLT_AC;                                                // [RQ17]
        end
    end

    // =========================================================================
    // pointer and counter
    wire [31:0] step     = {29'h0, nbytes};                                    // [RQ12]
    wire [31:0] ptr_mv   = flags.direction_flag ? ptr - step : ptr + step;     // [RQ11]
    // 16-bit pointer wraps inside its low half and leaves the upper half alone
    wire [31:0] ptr_next = size16 ? {ptr[31:16], ptr_mv[15:0]} : ptr_mv;
    wire        rep_zero = is_scan & iter_pfx & (rcnt == 32'h0);               // [RQ21]
    wire        again    = is_scan & iter_pfx & (rcnt != 32'h1);               // [RQ13]

    // =========================================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        fin     = 1'b0;
        commit  = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!legal || rep_zero) begin
                    state_d = ST_IDLE;
                    fin     = 1'b1;
                end else if (!uses_mem) begin
                    state_d = ST_EXEC;
                end else if (chk_fault != FLT_NONE) begin
                    state_d = ST_IDLE;                                         // [RQ20]
                    fin     = 1'b1;
                end else begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                if (i_mem.ack) begin
                    state_d = i_mem.page_fault ? ST_IDLE : ST_EXEC;            // [RQ20]
                    fin     = i_mem.page_fault;
                end
            end
            ST_EXEC: begin
                if (mem_dest) begin
                    state_d = ST_WRITE;
                end else begin
                    commit  = 1'b1;
                    state_d = again ? ST_CHECK : ST_IDLE;                      // [RQ13]
                    fin     = ~again;
                end
            end
            ST_WRITE: begin
                if (i_mem.ack) begin
                    // flags wait for the write so a page fault leaves them intact
                    commit  = ~i_mem.page_fault;                               // [RQ20]
                    state_d = ST_IDLE;
                    fin     = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            state_q <= ST_IDLE;
            o_busy  <= 1'b0;
            o_done  <= 1'b0;
        end else begin
            state_q <= state_d;
            o_busy  <= state_d != ST_IDLE;
            o_done  <= fin;
        end
    end

    // =========================================================================
    // register file: bus writes only while idle, commits only while busy
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            for (int i = 0; i < REG_WORDS; i++) begin
                regs_q[i] <= RESET_WORD;
            end
        end else if (bus_wr) begin
            regs_q[bus_idx[3:0]] <= (bus_idx == OFF_CTRL[7:2])
                                  ? {1'b0, wr_word[30:0]} : wr_word;
        end else if (commit) begin
            regs_q[OFF_FLAGS[5:2]] <= {25'h0, new_flags};                      // [RQ6] [RQ7] [RQ19]
            if (is_acc) begin
                regs_q[OFF_ACC[5:2]] <= (acc & ~wmask) | res;                  // [RQ3]
            end
            if (is_regdst | ((is_grp | is_rmdst) & ~rm_mem)) begin
                regs_q[OFF_DEST[5:2]] <= (dst & ~wmask) | res;                 // [RQ1]
            end
            if (is_scan) begin
                regs_q[OFF_SPTR[5:2]] <= ptr_next;                             // [RQ11]
                if (iter_pfx) begin
                    regs_q[OFF_RCNT[5:2]] <= rcnt - 32'h1;                     // [RQ21]
                end
            end
        end
    end

    // =========================================================================
    // memory port
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_mem    <= '0;
            memdat_q <= 32'h0;
        end else begin
            if (state_q == ST_CHECK && state_d == ST_READ) begin
                o_mem.req    <= 1'b1;
                o_mem.we     <= 1'b0;
                o_mem.addr   <= lin;                                           // [RQ9]
                o_mem.nbytes <= nbytes;
            end else if (state_q == ST_EXEC && state_d == ST_WRITE) begin
                o_mem.req    <= 1'b1;
                o_mem.we     <= 1'b1;
                o_mem.wdata  <= res;                                           // [RQ1]
            end else if (i_mem.ack) begin
                o_mem.req    <= 1'b0;
            end
            if (state_q == ST_READ && i_mem.ack) begin
                memdat_q <= i_mem.rdata & wmask;
            end
        end
    end

    // =========================================================================
    // completion status, cleared by the next start
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            done_q    <= 1'b0;
            illegal_q <= 1'b0;
            fkind_q   <= FLT_NONE;
            errv_q    <= 1'b0;
            fcode_q   <= 16'h0;
        end else if (start) begin
            done_q    <= 1'b0;
            illegal_q <= 1'b0;
            fkind_q   <= FLT_NONE;
            errv_q    <= 1'b0;
            fcode_q   <= 16'h0;
        end else begin
            if (fin) begin
                done_q <= 1'b1;
            end
            if (state_q == ST_CHECK && !legal) begin
                illegal_q <= 1'b1;
            end
            if (state_q == ST_CHECK && legal && !rep_zero && uses_mem
                && chk_fault != FLT_NONE) begin
                fkind_q <= chk_fault;
                errv_q  <= mode != MODE_REAL;                                  // [RQ14] [RQ18]
            end
            if ((state_q == ST_READ || state_q == ST_WRITE)
                && i_mem.ack && i_mem.page_fault) begin
                fkind_q <= FLT_PF;                                             // [RQ16]
                errv_q  <= 1'b1;
                fcode_q <= i_mem.fault_code;                                   // [RQ16]
            end
        end
    end

    // =========================================================================
    // bus answer: one wait state, unmapped words read zero
    wire [31:0] status_word = {fcode_q, 8'h0, errv_q, fkind_q, fkind_q != FLT_NONE,
                               illegal_q, done_q, state_q != ST_IDLE};
    wire [31:0] rd_word = (bus_idx == OFF_STATUS[7:2]) ? status_word
                        : (bus_map ? regs_q[bus_idx[3:0]] : 32'h0);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= bus_req;
            if (bus_req && !i_wb_we) begin
                o_wb_dat <= rd_word;
            end
        end
    end

endmodule

// ### logic/bssc_pkg.sv
/*
 * Shared definitions for the borrow-subtract / scan-compare datapath:
 * register map, control and status field positions, opcodes, states
 * and the carriers of the data-memory port.
 * Assumes a 32-bit classic Wishbone register bus and a same-clock memory port.
 */
package bssc_pkg;

    // =========================================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_FLAGS   = 8'h04;
    localparam logic [7:0] OFF_DEST    = 8'h08;
    localparam logic [7:0] OFF_SRC     = 8'h0c;
    localparam logic [7:0] OFF_ACC     = 8'h10;
    localparam logic [7:0] OFF_MADDR   = 8'h14;
    localparam logic [7:0] OFF_MBASE   = 8'h18;
    localparam logic [7:0] OFF_MLIMIT  = 8'h1c;
    localparam logic [7:0] OFF_SPTR    = 8'h20;
    localparam logic [7:0] OFF_SBASE   = 8'h24;
    localparam logic [7:0] OFF_SLIMIT  = 8'h28;
    localparam logic [7:0] OFF_RCNT    = 8'h2c;
    localparam logic [7:0] OFF_STATUS  = 8'h30;
    localparam int         REG_WORDS   = 12;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // =========================================================================
    // control word fields
    localparam int CTRL_OPC_LSB   = 0;
    localparam int CTRL_REG_LSB   = 8;
    localparam int CTRL_RM_MEM    = 11;
    localparam int CTRL_SIZE16    = 12;
    localparam int CTRL_ITER_PFX  = 13;
    localparam int CTRL_MODE_LSB  = 14;
    localparam int CTRL_CPL_LSB   = 16;
    localparam int CTRL_AC_EN     = 18;
    localparam int CTRL_MSEG_WR   = 19;
    localparam int CTRL_MSEG_NULL = 20;
    localparam int CTRL_MSEG_STK  = 21;
    localparam int CTRL_SSEG_NULL = 22;
    localparam int CTRL_START     = 31;

    // =========================================================================
    // status word fields
    localparam int STAT_BUSY      = 0;
    localparam int STAT_DONE      = 1;
    localparam int STAT_ILLEGAL   = 2;
    localparam int STAT_FAULT     = 3;
    localparam int STAT_KIND_LSB  = 4;
    localparam int STAT_ERRV      = 7;
    localparam int STAT_CODE_LSB  = 16;

    // =========================================================================
    // opcodes and constants
    localparam logic [7:0] OPC_RM_REG_B  = 8'h18;
    localparam logic [7:0] OPC_RM_REG_W  = 8'h19;
    localparam logic [7:0] OPC_REG_RM_B  = 8'h1a;
    localparam logic [7:0] OPC_REG_RM_W  = 8'h1b;
    localparam logic [7:0] OPC_ACC_IMM_B = 8'h1c;
    localparam logic [7:0] OPC_ACC_IMM_W = 8'h1d;
    localparam logic [7:0] OPC_GRP_IMM_B = 8'h80;
    localparam logic [7:0] OPC_GRP_IMM_W = 8'h81;
    localparam logic [7:0] OPC_GRP_IMM_S = 8'h83;
    localparam logic [7:0] OPC_SCAN_B    = 8'hae;
    localparam logic [7:0] OPC_SCAN_W    = 8'haf;
    localparam logic [2:0] GRP_SBB_SEL   = 3'h3;
    localparam logic [1:0] CPL_USER      = 2'h3;

    // =========================================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_READ  = 3'b010,
        ST_EXEC  = 3'b011,
        ST_WRITE = 3'b100
    } bssc_state_t;

    typedef enum logic [1:0] {
        MODE_REAL = 2'b00,
        MODE_PROT = 2'b01,
        MODE_V86  = 2'b10
    } bssc_mode_t;

    typedef enum logic [2:0] {
        FLT_NONE = 3'b000,
        FLT_GP   = 3'b001,
        FLT_SS   = 3'b010,
        FLT_PF   = 3'b011,
        FLT_AC   = 3'b100
    } bssc_fault_t;

    typedef struct packed {
        logic direction_flag;
        logic overflow_flag;
        logic sign_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic parity_flag;
        logic carry_flag;
    } bssc_flags_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [2:0]  nbytes;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bssc_mem_req_t;

    typedef struct packed {
        logic        ack;
        logic        page_fault;
        logic [15:0] fault_code;
        logic [31:0] rdata;
    } bssc_mem_rsp_t;

endpackage

// ### testbench/bssc_core_assertions.sv
/* Port checker for bssc_core, bound to every instance.
   Assumes one clock, i_sys_clk, and synchronous active-low i_resetn. */
`timescale 1ns/1ps
module bssc_chk import bssc_pkg::*; (
    input wire logic          i_sys_clk,
    input wire logic          i_resetn,
    input wire logic          i_wb_cyc,
    input wire logic          i_wb_stb,
    input wire logic          i_wb_we,
    input wire logic [7:0]    i_wb_adr,
    input wire logic [3:0]    i_wb_sel,
    input wire logic [31:0]   i_wb_dat,
    input wire logic          o_wb_ack,
    input wire bssc_mem_req_t o_mem,
    input wire bssc_mem_rsp_t i_mem,
    input wire logic          o_busy,
    input wire logic          o_done
);
    // ==== properties
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    wire req_seen = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire start_wr = req_seen && i_wb_we && i_wb_adr[7:2] == 6'h00 && i_wb_dat[31] && i_wb_sel[3];
    a_bus_answer: assert property (req_seen |=> o_wb_ack) else $error("no ack");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
    a_done_pulse: assert property (o_done |=> !o_done) else $error("done held");
    a_start_done: assert property (start_wr && !o_busy |-> ##[2:1000] o_done)
        else $error("no done");
    a_req_hold: assert property (o_mem.req && !i_mem.ack |=> o_mem.req && $stable(o_mem.addr)
        && $stable(o_mem.we)) else $error("req moved");
    a_req_drop: assert property (o_mem.req && i_mem.ack |=> !o_mem.req) else $error("req stuck");
    a_unit_size: assert property (o_mem.req |-> o_mem.nbytes inside {3'h1, 3'h2, 3'h4})
        else $error("bad size");
    a_req_busy: assert property (o_mem.req |-> o_busy && !o_done) else $error("idle req");
    a_reset_quiet: assert property (disable iff (1'b0) !i_resetn |=> !o_busy && !o_done
        && !o_mem.req && !o_wb_ack) else $error("live in reset");
    c_mem_write: cover property (o_mem.req && o_mem.we && i_mem.ack);
    c_page_fault: cover property (i_mem.ack && i_mem.page_fault);
    c_done: cover property (o_done);
endmodule
bind bssc_core bssc_chk u_chk (.*);

// ### testbench/bssc_mem_model.sv
/* Behavioural data memory on the bssc_core memory port.
   Assumes byte addressing on the low 8 address bits, latency set by i_lat. */
`timescale 1ns/1ps
module bssc_mem_model import bssc_pkg::*; (
    input  wire logic          i_clk,
    input  wire bssc_mem_req_t i_req,
    input  wire logic [3:0]    i_lat,
    input  wire logic          i_pf,
    output bssc_mem_rsp_t      o_rsp = '0,
    output logic [31:0]        o_last_adr = '0
);
    localparam logic [15:0] PF_CODE = 16'h0005;
    logic [7:0] mem_q [256];
    logic [3:0] wait_q = 4'h0;
    wire  [7:0] a = i_req.addr[7:0];
    initial foreach (mem_q[i]) mem_q[i] = 8'h00;
    always @(posedge i_clk) begin
        // stale data must not look valid outside an answer
        o_rsp.rdata <= ~o_rsp.rdata;
        o_rsp.ack <= 1'b0;
        if (i_req.req && !o_rsp.ack) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= i_lat) begin
                wait_q <= 4'h0;
                o_rsp.ack <= 1'b1;
                o_rsp.page_fault <= i_pf;
                o_rsp.fault_code <= i_pf ? PF_CODE : 16'h0000;
                o_rsp.rdata <= {mem_q[a+8'h3], mem_q[a+8'h2], mem_q[a+8'h1], mem_q[a]};
                o_last_adr <= i_req.addr;
                for (int k = 0; k < 4; k++) begin
                    if (i_req.we && !i_pf && k < i_req.nbytes)
                        mem_q[a+k] <= i_req.wdata[8*k+:8];
                end
            end
        end
    end
endmodule

// ### testbench/tb_top.sv
/* Self-checking bench for bssc_core over classic Wishbone.
   Assumes the bound checker and the behavioural memory model. */
`timescale 1ns/1ps
module tb_top import bssc_pkg::*; ;
    logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, pf = 0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, lat = 4'h0;
    logic [31:0] dat = 32'h0, rdata, last_adr;
    logic ack, busy, done;
    bssc_mem_req_t mreq;
    bssc_mem_rsp_t mrsp;
    int err_total = 0, checks_done = 0, n_done = 0;
    logic [31:0] fc [4] = '{32'h8008_4b80, 32'h8008_0b80, 32'h8028_0b80, 32'h8028_8b80};
    logic [31:0] fs [4] = '{32'h0000_009a, 32'h0000_001a, 32'h0000_002a, 32'h0000_00aa};
    bssc_core u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdata),
        .o_wb_ack(ack), .o_mem(mreq), .i_mem(mrsp), .o_busy(busy), .o_done(done));
    bssc_mem_model u_mem (.i_clk(clk), .i_req(mreq), .i_lat(lat), .i_pf(pf), .o_rsp(mrsp),
        .o_last_adr(last_adr));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (done === 1'b1) n_done++;
    // ==== tasks
    task ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) ck("wb_ack", 32'h0, 32'h1);
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        ck(nm, rdata, exp);
    endtask
    task automatic run(input logic [31:0] c);
        int n = 0, seen = n_done;
        wb(1'b1, OFF_CTRL, c);
        while (n_done == seen && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) ck("done", 32'h0, 32'h1);
    endtask
    task print_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ==== tests
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(OFF_STATUS, "status_rst", RESET_WORD);
        rd(8'h3c, "unmapped", 32'h0);
        wb(1'b1, OFF_FLAGS, 32'h1);
        wb(1'b1, OFF_ACC, 32'h1234_5680);
        wb(1'b1, OFF_SRC, 32'h0000_0001);
        run(32'h8000_001c);
        rd(OFF_ACC, "acc_sbb", 32'h1234_567e);
        rd(OFF_FLAGS, "flags_sbb", 32'h0000_0026);
        wb(1'b1, OFF_FLAGS, 32'h0);
        wb(1'b1, OFF_DEST, 32'h0);
        wb(1'b1, OFF_SRC, 32'h0000_00ff);
        run(32'h8000_0383);
        rd(OFF_DEST, "dest_sext", 32'h0000_0001);
        rd(OFF_FLAGS, "flags_sext", 32'h0000_0005);
        u_mem.mem_q[8'h44] = 8'h10;
        u_mem.mem_q[8'h30] = 8'h05;
        lat <= 4'h3;
        wb(1'b1, OFF_MBASE, 32'h40);
        wb(1'b1, OFF_MADDR, 32'h4);
        wb(1'b1, OFF_MLIMIT, 32'hff);
        run(32'h8000_0818);
        ck("mem_dest", {24'h0, u_mem.mem_q[8'h44]}, 32'h10);
        ck("mem_adr", last_adr, 32'h44);
        wb(1'b1, OFF_ACC, 32'h5);
        wb(1'b1, OFF_SBASE, 32'h20);
        wb(1'b1, OFF_SLIMIT, 32'hffff_ffff);
        wb(1'b1, OFF_SPTR, 32'h10);
        run(32'h8000_00af);
        ck("scan_adr", last_adr, 32'h30);
        rd(OFF_SPTR, "sptr_dw", 32'h14);
        rd(OFF_FLAGS, "flags_scan", 32'h0000_000a);
        rd(OFF_ACC, "acc_scan", 32'h5);
        wb(1'b1, OFF_SPTR, 32'h0001_fffe);
        run(32'h8000_10af);
        ck("scan16_adr", last_adr, 32'h0001_001e);
        rd(OFF_SPTR, "sptr_w", 32'h0001_0000);
        wb(1'b1, OFF_FLAGS, 32'h40);
        wb(1'b1, OFF_SPTR, 32'h14);
        wb(1'b1, OFF_RCNT, 32'h3);
        run(32'h8000_20ae);
        rd(OFF_SPTR, "sptr_rep", 32'h11);
        rd(OFF_RCNT, "rcnt_rep", 32'h0);
        rd(OFF_FLAGS, "flags_rep", 32'h42);
        wb(1'b1, OFF_MADDR, 32'h20);
        wb(1'b1, OFF_MLIMIT, 32'h10);
        for (int i = 0; i < 4; i++) begin
            run(fc[i]);
            rd(OFF_STATUS, "status_fault", fs[i]);
        end
        rd(OFF_FLAGS, "flags_kept", 32'h42);
        wb(1'b1, OFF_MADDR, 32'h4);
        wb(1'b1, OFF_MLIMIT, 32'hff);
        pf <= 1'b1;
        run(32'h8000_0818);
        rd(OFF_STATUS, "status_pf", 32'h0005_00ba);
        ck("mem_kept", {24'h0, u_mem.mem_q[8'h44]}, 32'h10);
        print_verdict();
    end
    initial begin
        #200000;
        ck("watchdog", 32'h0, 32'h1);
        print_verdict();
    end
endmodule
